/* bench/fcd_flash_host_bench.sv */
/* Self-checking bench for the flash host with a flash model.
   Assumes fcd_pkg, the host, the model and the bound checker. */
`timescale 1ns/1ps
module fcd_flash_host_bench;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary identity value
	localparam logic [7:0] PART = 8'h5B; // Arbitrary identity value
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] aa = '0;
	logic rq = 1'b0;
	logic wq = 1'b0;
	logic [31:0] wdt = '0;
	logic [31:0] rdat, st, avs_rd;
	logic wt, ce, oe, we, doe, rpn, hv, rbn;
	logic [20:0] fa;
	logic [7:0] fin, fout, pd [4];
	logic [20:0] pa [4];
	int fail_count = 0;
	int checks = 0;
	int seed = 64;

	always #2 clk = !clk;

	fcd_flash_host u_fcd_flash_host (.clk(clk), .rstn(rstn), .avs_address(aa), .avs_read(rq), .avs_write(wq),
		.avs_byteenable(4'hF), .avs_writedata(wdt), .avs_readdata(avs_rd), .avs_waitrequest(wt),
		.flash_addr(fa), .flash_ce_n(ce), .flash_oe_n(oe), .flash_we_n(we), .flash_dq_in(fin),
		.flash_dq_out(fout), .flash_dq_oe(doe), .reset_powerdown_n(rpn),
		.unlock_high_voltage_level(hv), .ready_busy_n(rbn));
	fcd_flash_model #(.MAKER(MAKER), .PART(PART)) u_fcd_flash_model (.addr(fa), .ce_n(ce), .oe_n(oe),
		.we_n(we), .wd(fout), .rd(fin), .rp_n(rpn), .hv(hv), .rb_n(rbn));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// Array byte once block 2 is erased
	function automatic logic [7:0] exp_arr(input int i);
		return (pa[i][20:16] == 5'h02) ? 8'hFF : pd[i];
	endfunction
	task automatic bw(input logic [4:0] a, input logic [31:0] d);
		aa <= a;
		wdt <= d;
		wq <= 1'b1;
		do @(posedge clk); while (wt !== 1'b0);
		wq <= 1'b0;
		@(posedge clk);
	endtask
	task automatic br(input logic [4:0] a);
		aa <= a;
		rq <= 1'b1;
		do @(posedge clk); while (wt !== 1'b0);
		rdat = avs_rd;
		rq <= 1'b0;
		@(posedge clk);
	endtask
	task automatic poll;
		do br(5'h0C); while (rdat[0] !== 1'b0);
		st = rdat;
	endtask
	task automatic op(input logic [3:0] o);
		bw(5'h00, {28'h0, o});
		poll();
	endtask
	task automatic rdy;
		do br(5'h0C); while (rdat[2] !== 1'b1);
	endtask
	task automatic fr(input logic [20:0] a, input logic [3:0] o);
		bw(5'h04, {11'h0, a});
		op(o);
	endtask
	task automatic give_verdict;
		$display("checks %0d, fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#240000;
		fail_count++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		poll();
		chk("mode", 0, st[5:4]);
		br(5'h14);
		chk("unmapped", 0, rdat);
		fr(21'h0, fcd_pkg::OP_READ_ID);
		chk("maker", MAKER, st[15:8]);
		chk("idmode", 1, st[5:4]);
		fr(21'h1, fcd_pkg::OP_READ_ID);
		chk("part", PART, st[15:8]);
		fr(21'h3, fcd_pkg::OP_READ_ID);
		chk("mlock", 0, st[15:8]);
		fr(21'h0, fcd_pkg::OP_BUS_READ);
		chk("idkeep", MAKER, st[15:8]);
		op(fcd_pkg::OP_READ_STATUS);
		chk("status", 8'h80, st[15:8]);
		for (int i = 0; i < 4; i++) begin
			pa[i] = {5'(i), 16'($random(seed))};
			pd[i] = 8'($random(seed));
			bw(5'h08, {24'h0, pd[i]});
			fr(pa[i], fcd_pkg::OP_PROGRAM);
			chk("pmode", 2, st[5:4]);
			rdy();
			op(fcd_pkg::OP_READ_ARRAY);
			fr(pa[i], fcd_pkg::OP_BUS_READ);
			chk("pdata", pd[i], st[15:8]);
		end
		fr(21'h090100, fcd_pkg::OP_SET_BLOCK_LOCK);
		op(fcd_pkg::OP_LOCK_QUERY);
		chk("block lock", 1, st[15:8]);
		fr(21'h090100, fcd_pkg::OP_PROGRAM);
		rdy();
		op(fcd_pkg::OP_READ_STATUS);
		chk("locked prog", 8'h92, st[15:8]);
		bw(5'h00, {28'h0, fcd_pkg::OP_CLEAR_STATUS});
		op(fcd_pkg::OP_READ_STATUS);
		chk("cleared", 8'h80, st[15:8]);
		bw(5'h10, 32'h1);
		op(fcd_pkg::OP_CLEAR_LOCKS);
		op(fcd_pkg::OP_LOCK_QUERY);
		chk("locks cleared", 0, st[15:8]);
		bw(5'h10, 32'h0);
		op(fcd_pkg::OP_SET_MASTER_LOCK);
		chk("ml refused", 1, st[1]);
		bw(5'h10, 32'h1);
		fr(21'h3, fcd_pkg::OP_SET_MASTER_LOCK);
		op(fcd_pkg::OP_READ_ID);
		chk("ml set", 1, st[15:8]);
		fr(21'h020000, fcd_pkg::OP_ERASE);
		chk("emode", 2, st[5:4]);
		op(fcd_pkg::OP_READ_ARRAY);
		chk("busy refuse", 1, st[1]);
		op(fcd_pkg::OP_SUSPEND);
		rdy();
		op(fcd_pkg::OP_READ_ARRAY);
		chk("susp read", 0, st[1]);
		op(fcd_pkg::OP_CLEAR_STATUS);
		chk("susp clear", 1, st[1]);
		op(fcd_pkg::OP_RESUME);
		op(fcd_pkg::OP_READ_STATUS);
		chk("resumed", 0, st[15]);
		rdy();
		bw(5'h00, 32'hE);
		poll();
		chk("bad op", 1, st[1]);
		op(fcd_pkg::OP_POWER_DOWN);
		chk("pd mode", 0, st[5:4]);
		for (int i = 0; i < 4; i++) begin
			fr(pa[i], fcd_pkg::OP_BUS_READ);
			chk("pd array", exp_arr(i), st[15:8]);
		end
		op(fcd_pkg::OP_READ_STATUS);
		chk("pd status", 8'h80, st[15:8]);
		give_verdict();
	end
endmodule // fcd_flash_host_bench

/* bench/fcd_flash_host_monitor.sv */
/* Checker for the flash host: pin strobes and bus answers.
   Assumes it is bound to fcd_flash_host. */
`timescale 1ns/1ps
module fcd_flash_host_monitor #(parameter int ADDR_W = 21) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Flash pins
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [7:0] flash_dq_in,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic reset_powerdown_n,
	input wire logic unlock_high_voltage_level,
	input wire logic ready_busy_n
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_rst_pd; $rose(rstn) |-> !reset_powerdown_n[*8]; endproperty
	property p_pd_hold; $fell(reset_powerdown_n) |-> !reset_powerdown_n[*8]; endproperty
	property p_pd_quiet; !reset_powerdown_n |-> flash_ce_n && flash_we_n && flash_oe_n; endproperty
	property p_we_qual; !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe; endproperty
	property p_oe_qual; !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe; endproperty
	property p_we_len; $fell(flash_we_n) |-> !flash_we_n[*8]; endproperty
	property p_we_stable; !flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_out); endproperty
	property p_we_hold; $rose(flash_we_n) |-> ($stable(flash_addr) && flash_dq_oe)[*3]; endproperty
	property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
	property p_wr_fast; avs_write && avs_address[4:2] != fcd_pkg::REG_CTRL |-> !avs_waitrequest; endproperty
	a_rst_pd: assert property (p_rst_pd) else $error("power-down pin released too early");
	a_pd_hold: assert property (p_pd_hold) else $error("power-down pulse too short");
	a_pd_quiet: assert property (p_pd_quiet) else $error("strobe during power-down");
	a_we_qual: assert property (p_we_qual) else $error("write strobe without select");
	a_oe_qual: assert property (p_oe_qual) else $error("read strobe while driving");
	a_we_len: assert property (p_we_len) else $error("write strobe too short");
	a_we_stable: assert property (p_we_stable) else $error("write data moved in strobe");
	a_we_hold: assert property (p_we_hold) else $error("write data not held");
	a_rd_wait: assert property (p_rd_wait) else $error("read answer not after one wait");
	a_wr_fast: assert property (p_wr_fast) else $error("register write stalled");
	// Main scenarios
	c_write: cover property ($fell(flash_we_n));
	c_read: cover property ($fell(flash_oe_n));
	c_pd: cover property ($fell(reset_powerdown_n));
endmodule // fcd_flash_host_monitor

bind fcd_flash_host fcd_flash_host_monitor #(.ADDR_W(ADDR_W)) u_fcd_flash_host_monitor (.clk(clk), .rstn(rstn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.reset_powerdown_n(reset_powerdown_n), .unlock_high_voltage_level(unlock_high_voltage_level),
	.ready_busy_n(ready_busy_n));

/* bench/fcd_flash_model.sv */
/* Behavioural byte-wide flash: command decoder, identifier and status.
   Assumes the host drives the strobes; no clock of its own. */
`timescale 1ns/1ps
module fcd_flash_model #(
	parameter logic [7:0] MAKER = 8'h3C, // Arbitrary
	parameter logic [7:0] PART = 8'h5B, // Arbitrary
	parameter int BUSY_NS = 2000
) (
	// Host bus
	input wire logic [20:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] wd,
	output logic [7:0] rd,
	// Reset, high voltage and ready
	input wire logic rp_n,
	input wire logic hv,
	output logic rb_n
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] mem [logic [20:0]];
	logic [31:0] lk = '0;
	logic ml = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] pend = 8'h00;
	logic [7:0] sr = 8'h80;
	logic busy = 1'b0;
	logic sus = 1'b0;
	logic flip = 1'b0;
	int left = 0;
	wire wr = !ce_n && !we_n && rp_n;
	wire vhh = rp_n && hv;

	// Data seen by the host in each read mode
	function automatic logic [7:0] rdv(input logic [20:0] a, input logic [1:0] m);
		if (m == 2'h0) return mem.exists(a) ? mem[a] : 8'hFF;
		if (m == 2'h1) begin
			case (a[15:0])
				16'h0000: return MAKER;
				16'h0001: return PART;
				16'h0002: return {7'h00, lk[a[20:16]]};
				16'h0003: return {7'h00, ml};
				default: return 8'h00;
			endcase
		end
		return {!busy || sus, sr[6:0]};
	endfunction

	// Released bus shows a toggling pattern
	always #4 flip = !flip;
	assign rd = (!ce_n && !oe_n && rp_n) ? rdv(addr, mode) : ({8{flip}} ^ 8'h5A);
	assign rb_n = !busy || sus || !rp_n;

	// Deep power-down resets mode and status
	always @(negedge rp_n) begin
		mode = 2'h0;
		pend = 8'h00;
		sr = 8'h80;
		busy = 1'b0;
		sus = 1'b0;
	end

	// Write state machine, frozen while suspended
	always #10 if (busy && !sus && rp_n) begin
		left--;
		if (left <= 0) busy = 1'b0;
	end

	// Command taken when the first strobe rises
	always @(negedge wr) begin : cmd
		logic [7:0] d;
		logic lkd;
		d = wd;
		lkd = lk[addr[20:16]];
		if (pend == 8'h20) begin
			if (d != 8'hD0) sr |= 8'h30;
			else if (lkd && !vhh) sr |= 8'h22;
			else begin
				busy = 1'b1;
				left = BUSY_NS / 10;
				foreach (mem[k]) if (k[20:16] == addr[20:16]) mem[k] = 8'hFF;
			end
			mode = 2'h2;
			pend = 8'h00;
		end else if (pend == 8'h40 || pend == 8'h10) begin
			if (lkd && !vhh) sr |= 8'h12;
			else begin mem[addr] = rdv(addr, 2'h0) & d; busy = 1'b1; left = BUSY_NS / 10; end
			mode = 2'h2;
			pend = 8'h00;
		end else if (pend == 8'h60) begin
			if (d == 8'h01 && (!ml || vhh)) lk[addr[20:16]] = 1'b1;
			else if (d == 8'hF1 && vhh) ml = 1'b1;
			else if (d == 8'hD0 && (!ml || vhh)) lk = '0;
			else sr |= 8'h12;
			mode = 2'h2;
			pend = 8'h00;
		end else begin
			case (d)
				8'hFF: if (!busy || sus) mode = 2'h0;
				8'h90: mode = 2'h1;
				8'h70: mode = 2'h2;
				8'h50: if (!sus) sr &= 8'hC5;
				8'h20, 8'h40, 8'h10, 8'h60: pend = d;
				8'hB0: if (busy) begin sus = 1'b1; sr[6] = 1'b1; mode = 2'h2; end
				8'hD0: if (sus) begin sus = 1'b0; sr[6] = 1'b0; mode = 2'h2; end
				default: ;
			endcase
		end
	end
endmodule // fcd_flash_model

/* hdl/fcd_flash_host.sv */
/*
 * Host controller for a byte-wide block-erasable flash: turns register
 * orders into command bus cycles on the flash pins.
 * Assumes an Avalon-MM master with waitrequest and a flash wired to the pins.
 */
// Summary of operation
// - Read-array op writes FFH once; later reads return array data.
// - Identifier op writes 90H then reads; reads may repeat.
// - Status op writes 70H; reads then return status.
// - Erase writes 20H then D0H at the block address.
// - Program second cycle carries address and byte.
// - Suspend writes B0H once.
// - Resume writes D0H alone.
// - Only defined command codes and program data bytes are ever written.
// - Clear status writes 50H; refused while suspended.
`timescale 1ns/1ps
module fcd_flash_host #(
	parameter int ADDR_W = 21
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Flash pins
	output logic [ADDR_W-1:0] flash_addr,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic [7:0] flash_dq_in,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic reset_powerdown_n,
	output logic unlock_high_voltage_level,
	input wire logic ready_busy_n
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STROBE = 6'h04,
		ST_HOLD = 6'h08,
		ST_PWR = 6'h10,
		ST_WAKE = 6'h20
	} fcd_state_e;

	localparam logic [7:0] C_SETUP = 8'(fcd_pkg::SETUP_CYC);
	localparam logic [7:0] C_WRITE = 8'(fcd_pkg::WRITE_CYC);
	localparam logic [7:0] C_READ = 8'(fcd_pkg::READ_CYC);
	localparam logic [7:0] C_HOLD = 8'(fcd_pkg::HOLD_CYC);
	localparam logic [7:0] C_PWR = 8'(fcd_pkg::PWRDN_CYC);
	localparam logic [7:0] C_WAKE = 8'(fcd_pkg::WAKE_CYC);

	fcd_state_e state_ff;
	logic [7:0] cnt_ff;
	logic cyc_ff;
	logic two_ff;
	logic rd2_ff;
	logic [7:0] code0_ff;
	logic [7:0] code1_ff;
	logic [ADDR_W-1:0] addr1_ff;
	logic [31:0] addr_reg_ff;
	logic [7:0] wdata_ff;
	logic hv_ff;
	logic [7:0] rdata_ff;
	logic refused_ff;
	logic susp_ff;
	logic [1:0] mode_ff;
	logic rd_done_ff;
	logic [31:0] readdata_ff;
	logic [2:0] idx;
	logic busy;
	logic wr_acc;
	logic start;
	logic [3:0] op;
	logic rdy;
	logic nxt_two;
	logic nxt_rd2;
	logic [7:0] nxt_code0;
	logic [7:0] nxt_code1;
	logic [ADDR_W-1:0] nxt_addr1;
	logic [1:0] nxt_mode;
	logic nxt_refuse;
	logic is_pwr;
	logic [ADDR_W-1:0] op_addr;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	fcd_sync_if #(.W(8)) dq_if (.clk(clk), .rstn(rstn));
	fcd_sync_if #(.W(1)) rb_if (.clk(clk), .rstn(rstn));
	fcd_sync3 #(.W(8), .RST(8'h00)) u_dq_sync (.s(dq_if.sync));
	fcd_sync3 #(.W(1), .RST(1'b1)) u_rb_sync (.s(rb_if.sync));
	assign dq_if.raw = flash_dq_in;
	assign rb_if.raw = ready_busy_n;
	assign rdy = rb_if.val[0];

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	assign idx = avs_address[4:2];
	assign busy = (state_ff != ST_IDLE);
	assign op = avs_writedata[3:0];
	// Reads take one wait cycle; CTRL writes stall while busy
	assign avs_waitrequest = (avs_read && !rd_done_ff) || (avs_write && idx == fcd_pkg::REG_CTRL && busy);
	assign wr_acc = avs_write && !avs_waitrequest;
	assign start = wr_acc && idx == fcd_pkg::REG_CTRL && avs_byteenable[0];
	assign avs_readdata = readdata_ff;

	// Read data register, unmapped words read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_done_ff <= 1'b0;
			readdata_ff <= 32'h0000_0000;
		end else begin
			rd_done_ff <= avs_read && !rd_done_ff;
			if (avs_read && !rd_done_ff) begin
				unique case (idx)
					fcd_pkg::REG_ADDR: readdata_ff <= addr_reg_ff;
					fcd_pkg::REG_WDATA: readdata_ff <= {24'h00_0000, wdata_ff};
					fcd_pkg::REG_STATUS: readdata_ff <= {16'h0000, rdata_ff, 2'h0, mode_ff, susp_ff, rdy, refused_ff, busy};
					fcd_pkg::REG_CFG: readdata_ff <= {31'h0000_0000, hv_ff};
					default: readdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Writable registers with byte enables
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_reg_ff <= fcd_pkg::RST_ADDR;
			wdata_ff <= fcd_pkg::RST_WDATA;
			hv_ff <= 1'b0;
		end else if (wr_acc) begin
			if (idx == fcd_pkg::REG_ADDR) begin
				for (int b = 0; b < 4; b++) begin
					if (avs_byteenable[b]) begin
						addr_reg_ff[b*8 +: 8] <= avs_writedata[b*8 +: 8];
					end
				end
			end
			if (idx == fcd_pkg::REG_WDATA && avs_byteenable[0]) begin
				wdata_ff <= avs_writedata[7:0];
			end
			if (idx == fcd_pkg::REG_CFG && avs_byteenable[0]) begin
				hv_ff <= avs_writedata[0];
			end
		end
	end

	// High-voltage level request on the reset pin
	assign unlock_high_voltage_level = hv_ff;

	// ------------------------------------------------------------
	// Op decode into one or two bus cycles, a power-down pulse or a refusal
	// ------------------------------------------------------------
	assign op_addr = addr_reg_ff[ADDR_W-1:0];
	always_comb begin
		nxt_two = 1'b0;
		nxt_rd2 = 1'b0;
		nxt_code0 = fcd_pkg::CMD_READ_ARRAY;
		nxt_code1 = fcd_pkg::CMD_READ_ARRAY;
		nxt_addr1 = op_addr;
		nxt_mode = mode_ff;
		nxt_refuse = 1'b0;
		is_pwr = 1'b0;
		unique case (op)
			fcd_pkg::OP_READ_ARRAY: begin
				nxt_refuse = !rdy && !susp_ff;
				nxt_mode = fcd_pkg::MODE_ARRAY;
			end
			fcd_pkg::OP_READ_ID: begin
				nxt_code0 = fcd_pkg::CMD_READ_ID;
				nxt_two = 1'b1;
				nxt_rd2 = 1'b1;
				nxt_mode = fcd_pkg::MODE_ID;
			end
			fcd_pkg::OP_LOCK_QUERY: begin
				nxt_code0 = fcd_pkg::CMD_READ_ID;
				nxt_two = 1'b1;
				nxt_rd2 = 1'b1;
				nxt_addr1 = {op_addr[ADDR_W-1:fcd_pkg::BLOCK_OFS_W], fcd_pkg::ID_BLOCK_LOCK_OFS};
				nxt_mode = fcd_pkg::MODE_ID;
			end
			fcd_pkg::OP_READ_STATUS: begin
				nxt_code0 = fcd_pkg::CMD_READ_STATUS;
				nxt_two = 1'b1;
				nxt_rd2 = 1'b1;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_CLEAR_STATUS: begin
				nxt_code0 = fcd_pkg::CMD_CLEAR_STATUS;
				nxt_refuse = susp_ff;
			end
			fcd_pkg::OP_ERASE: begin
				nxt_code0 = fcd_pkg::CMD_ERASE_SETUP;
				nxt_code1 = fcd_pkg::CMD_CONFIRM;
				nxt_two = 1'b1;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_PROGRAM: begin
				nxt_code0 = fcd_pkg::CMD_PROGRAM_SETUP;
				nxt_code1 = wdata_ff;
				nxt_two = 1'b1;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_SUSPEND: begin
				nxt_code0 = fcd_pkg::CMD_SUSPEND;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_RESUME: begin
				nxt_code0 = fcd_pkg::CMD_CONFIRM;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_SET_BLOCK_LOCK: begin
				nxt_code0 = fcd_pkg::CMD_LOCK_SETUP;
				nxt_code1 = fcd_pkg::CMD_BLOCK_LOCK;
				nxt_two = 1'b1;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_SET_MASTER_LOCK: begin
				nxt_code0 = fcd_pkg::CMD_LOCK_SETUP;
				nxt_code1 = fcd_pkg::CMD_MASTER_LOCK;
				nxt_two = 1'b1;
				nxt_refuse = !hv_ff;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_CLEAR_LOCKS: begin
				nxt_code0 = fcd_pkg::CMD_LOCK_SETUP;
				nxt_code1 = fcd_pkg::CMD_CONFIRM;
				nxt_two = 1'b1;
				nxt_mode = fcd_pkg::MODE_STATUS;
			end
			fcd_pkg::OP_BUS_READ: begin
				nxt_rd2 = 1'b1;
			end
			fcd_pkg::OP_POWER_DOWN: begin
				is_pwr = 1'b1;
				nxt_mode = fcd_pkg::MODE_ARRAY;
			end
			default: begin
				nxt_refuse = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Host-side mode and flags
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_ff <= fcd_pkg::MODE_ARRAY;
			susp_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else if (start) begin
			refused_ff <= nxt_refuse;
			if (!nxt_refuse) begin
				mode_ff <= nxt_mode;
				if (op == fcd_pkg::OP_SUSPEND) begin
					susp_ff <= 1'b1;
				end else if (op == fcd_pkg::OP_RESUME || is_pwr) begin
					susp_ff <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Bus-cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= ST_PWR;
			cnt_ff <= C_PWR;
			cyc_ff <= 1'b0;
			two_ff <= 1'b0;
			rd2_ff <= 1'b0;
			code0_ff <= fcd_pkg::CMD_READ_ARRAY;
			code1_ff <= fcd_pkg::CMD_READ_ARRAY;
			addr1_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start && !nxt_refuse) begin
						code0_ff <= nxt_code0;
						code1_ff <= nxt_code1;
						addr1_ff <= nxt_addr1;
						two_ff <= nxt_two;
						rd2_ff <= nxt_rd2;
						// A plain read has only its read cycle
						cyc_ff <= (op == fcd_pkg::OP_BUS_READ);
						state_ff <= is_pwr ? ST_PWR : ST_SETUP;
						cnt_ff <= is_pwr ? C_PWR : C_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_ff == 8'h00) begin
						state_ff <= ST_STROBE;
						cnt_ff <= (cyc_ff && rd2_ff) ? C_READ : C_WRITE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				ST_STROBE: begin
					if (cnt_ff == 8'h00) begin
						state_ff <= ST_HOLD;
						cnt_ff <= C_HOLD;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				ST_HOLD: begin
					if (cnt_ff != 8'h00) begin
						cnt_ff <= cnt_ff - 8'h01;
					end else if (!cyc_ff && two_ff) begin
						cyc_ff <= 1'b1;
						state_ff <= ST_SETUP;
						cnt_ff <= C_SETUP;
					end else begin
						state_ff <= ST_IDLE;
					end
				end
				ST_PWR: begin
					if (cnt_ff == 8'h00) begin
						state_ff <= ST_WAKE;
						cnt_ff <= C_WAKE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				ST_WAKE: begin
					if (cnt_ff == 8'h00) begin
						state_ff <= ST_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flash pin drive
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flash_addr <= '0;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_dq_out <= 8'h00;
			flash_dq_oe <= 1'b0;
			reset_powerdown_n <= 1'b0;
		end else begin
			reset_powerdown_n <= (state_ff != ST_PWR);
			if (state_ff == ST_SETUP) begin
				flash_ce_n <= 1'b0;
				flash_addr <= cyc_ff ? addr1_ff : op_addr;
				flash_dq_out <= cyc_ff ? code1_ff : code0_ff;
				flash_dq_oe <= !(cyc_ff && rd2_ff);
			end
			if (state_ff == ST_SETUP && cnt_ff == 8'h00) begin
				flash_oe_n <= !(cyc_ff && rd2_ff);
				flash_we_n <= cyc_ff && rd2_ff;
			end
			// Both strobes rise together; address and data held through hold
			if (state_ff == ST_STROBE && cnt_ff == 8'h00) begin
				flash_oe_n <= 1'b1;
				flash_we_n <= 1'b1;
				flash_ce_n <= 1'b1;
			end
			if (state_ff == ST_HOLD && cnt_ff == 8'h00) begin
				flash_dq_oe <= 1'b0;
			end
		end
	end

	// Read data captured at end of the read strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_ff <= 8'h00;
		end else if (state_ff == ST_STROBE && cnt_ff == 8'h00 && cyc_ff && rd2_ff) begin
			rdata_ff <= dq_if.val;
		end
	end
endmodule // fcd_flash_host

/* hdl/fcd_pkg.sv */
/*
 * Constants for the flash command sequencer: command codes, op codes,
 * register map, read modes and pin timing.
 * Assumes a 250 MHz clock and a byte-wide flash on an async bus.
 */
package fcd_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_SETUP_NS = 10;
	localparam int T_WRITE_NS = 50;
	localparam int T_READ_NS = 100;
	localparam int T_HOLD_NS = 10;
	localparam int T_PWRDN_NS = 100;
	localparam int T_WAKE_NS = 1000;
	localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_CYC = (T_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_CYC = 4;
	localparam int READ_CYC = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_CYC;
	localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PWRDN_CYC = (T_PWRDN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CYC = (T_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;

	// ------------------------------------------------------------
	// Flash command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_BLOCK_LOCK = 8'h01;
	localparam logic [7:0] CMD_MASTER_LOCK = 8'hF1;

	// ------------------------------------------------------------
	// Identifier offsets inside a 64 KB block
	// ------------------------------------------------------------
	localparam int BLOCK_OFS_W = 16;
	localparam logic [15:0] ID_MAKER_OFS = 16'h0000;
	localparam logic [15:0] ID_PART_OFS = 16'h0001;
	localparam logic [15:0] ID_BLOCK_LOCK_OFS = 16'h0002;
	localparam logic [15:0] ID_MASTER_LOCK_OFS = 16'h0003;

	// ------------------------------------------------------------
	// Operation codes written to CTRL[3:0]
	// ------------------------------------------------------------
	localparam logic [3:0] OP_READ_ARRAY = 4'h0;
	localparam logic [3:0] OP_READ_ID = 4'h1;
	localparam logic [3:0] OP_READ_STATUS = 4'h2;
	localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
	localparam logic [3:0] OP_ERASE = 4'h4;
	localparam logic [3:0] OP_PROGRAM = 4'h5;
	localparam logic [3:0] OP_SUSPEND = 4'h6;
	localparam logic [3:0] OP_RESUME = 4'h7;
	localparam logic [3:0] OP_SET_BLOCK_LOCK = 4'h8;
	localparam logic [3:0] OP_SET_MASTER_LOCK = 4'h9;
	localparam logic [3:0] OP_CLEAR_LOCKS = 4'hA;
	localparam logic [3:0] OP_BUS_READ = 4'hB;
	localparam logic [3:0] OP_POWER_DOWN = 4'hC;
	localparam logic [3:0] OP_LOCK_QUERY = 4'hD;

	// ------------------------------------------------------------
	// Register map (word index, byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_CFG = 3'h4;
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	localparam logic [7:0] RST_WDATA = 8'h00;

	// ------------------------------------------------------------
	// Host view of the read mode
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_ARRAY = 2'h0;
	localparam logic [1:0] MODE_ID = 2'h1;
	localparam logic [1:0] MODE_STATUS = 2'h2;
endpackage

/* hdl/fcd_sync3.sv */
/*
 * Three-stage synchroniser for pin inputs.
 * Assumes raw comes from outside the clock domain.
 */
`timescale 1ns/1ps
module fcd_sync3 #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	// Synchroniser side of the carrier
	fcd_sync_if.sync s
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] val_ff;

	// Three flip-flop chain, first stage seen only by the second
	always_ff @(posedge s.clk) begin
		if (!s.rstn) begin
			s1_ff <= RST;
			s2_ff <= RST;
			s3_ff <= RST;
		end else begin
			s1_ff <= s.raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Value follows only when stages two and three agree
	always_ff @(posedge s.clk) begin
		if (!s.rstn) begin
			val_ff <= RST;
		end else if (s.agree) begin
			val_ff <= s3_ff;
		end
	end

	assign s.val = val_ff;
	assign s.agree = (s2_ff == s3_ff);
endmodule // fcd_sync3

/* hdl/fcd_sync_if.sv */
/*
 * Carrier between the sequencer and its pin synchronisers.
 * Assumes clk and rstn of the single clock domain.
 */
`timescale 1ns/1ps
interface fcd_sync_if #(parameter int W = 8) (input wire logic clk, input wire logic rstn);
	logic [W-1:0] raw;
	logic [W-1:0] val;
	logic agree;
	modport sync (input clk, input rstn, input raw, output val, output agree);
	modport user (output raw, input val, input agree);
endinterface
